// *** inc/tap_pkg.sv ***
// Purpose: shared constants and types of the boundary-scan test logic
// Assumes: one test access port, fixed io_block count
// Notes:   instruction codes and io_block count are local choices
package tap_pkg;
  // ==========================================================================
  // controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } tap_state_t;

  // ==========================================================================
  // instruction register
  localparam int         IR_LEN       = 3;
  localparam logic [2:0] IR_CAPTURE   = 3'h1;
  localparam logic [2:0] INS_EXTEST   = 3'h0;
  localparam logic [2:0] INS_SAMPLE   = 3'h1;
  localparam logic [2:0] INS_USER_ONE = 3'h2;
  localparam logic [2:0] INS_USER_TWO = 3'h3;
  localparam logic [2:0] INS_READBACK = 3'h4;
  localparam logic [2:0] INS_CONFIG   = 3'h5;
  localparam logic [2:0] INS_BYPASS   = 3'h7;

  // ==========================================================================
  // boundary register layout
  localparam int IO_BLOCK_COUNT = 4;
  localparam int CELLS_PER_IO   = 3;
  localparam int BSR_TDO_T      = 0;
  localparam int BSR_TDO_O      = 1;
  localparam int BSR_FIRST_IO   = 2;
  localparam int CELL_OE        = 0;
  localparam int CELL_OUT       = 1;
  localparam int CELL_IN        = 2;
  localparam int BSR_LEN        = BSR_FIRST_IO + CELLS_PER_IO * IO_BLOCK_COUNT + 1;
  localparam int BSR_UPD        = BSR_LEN - 1;

  // configuration data register
  localparam int CFG_WORD_LEN   = 8;
endpackage

// *** hw/sync_2ff.sv ***
// Purpose: two-stage level synchroniser
// Assumes: inputs are levels or toggles, not pulses
// Notes:   first stage feeds only the second
`timescale 1ns/10ps
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule

// *** hw/boundary_chain.sv ***
// Purpose: boundary data register with update latches per io_block
// Assumes: runs on the test clock; pad and core levels arrive unsynchronised
// Notes:   special cells capture and shift, they have no update stage
`timescale 1ns/10ps
module boundary_chain
  import tap_pkg::*;
(
  input  wire logic                      tck_i,
  input  wire logic                      rst_n_i,
  input  wire logic                      capture_i,
  input  wire logic                      shift_i,
  input  wire logic                      update_i,
  input  wire logic                      extest_i,
  input  wire logic                      tdi_i,
  input  wire logic                      tdo_drive_i,
  input  wire logic                      tdo_value_i,
  input  wire logic [IO_BLOCK_COUNT-1:0] pad_in_i,
  input  wire logic [IO_BLOCK_COUNT-1:0] core_out_i,
  input  wire logic [IO_BLOCK_COUNT-1:0] core_oe_i,
  output logic      [IO_BLOCK_COUNT-1:0] pad_out_o,
  output logic      [IO_BLOCK_COUNT-1:0] pad_oe_o,
  output logic                           scan_out_o
);
  logic [BSR_LEN-1:0]        bsr_reg;
  logic [IO_BLOCK_COUNT-1:0] upd_out_reg;
  logic [IO_BLOCK_COUNT-1:0] upd_oe_reg;
  logic [IO_BLOCK_COUNT-1:0] pad_in_s;
  logic [IO_BLOCK_COUNT-1:0] core_out_s;
  logic [IO_BLOCK_COUNT-1:0] core_oe_s;
  logic [BSR_LEN-1:0]        cap_vec;

  sync_2ff #(.WIDTH(3 * IO_BLOCK_COUNT)) u_sync (
    .clk_i   (tck_i),
    .rst_n_i (rst_n_i),
    .d_i     ({pad_in_i, core_out_i, core_oe_i}),
    .q_o     ({pad_in_s, core_out_s, core_oe_s})
  );

  // ==========================================================================
  // capture image; internal nets reach the chain through out and oe cells
  always_comb begin
    cap_vec            = '0;
    cap_vec[BSR_TDO_T] = tdo_drive_i;
    cap_vec[BSR_TDO_O] = tdo_value_i;
    for (int i = 0; i < IO_BLOCK_COUNT; i++) begin
      cap_vec[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OE]  = core_oe_s[i];
      cap_vec[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OUT] = core_out_s[i];
      cap_vec[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_IN]  = pad_in_s[i];
    end
  end

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bsr_reg <= '0;
    end else if (capture_i) begin
      bsr_reg <= cap_vec;
    end else if (shift_i) begin
      bsr_reg <= {tdi_i, bsr_reg[BSR_LEN-1:1]};
    end
  end

  always_ff @(posedge tck_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      upd_out_reg <= '0;
      upd_oe_reg  <= '0;
    end else if (update_i) begin
      for (int i = 0; i < IO_BLOCK_COUNT; i++) begin
        upd_oe_reg[i]  <= bsr_reg[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OE];
        upd_out_reg[i] <= bsr_reg[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OUT];
      end
    end
  end

  // in external test every io_block becomes a bidirectional pin, whatever its user setup
  assign pad_out_o  = extest_i ? upd_out_reg : core_out_i;
  assign pad_oe_o   = extest_i ? upd_oe_reg : core_oe_i;
  assign scan_out_o = bsr_reg[BSR_TDO_T];

  // ==========================================================================
  // checks
  default clocking cb @(posedge tck_i); endclocking
  default disable iff (!rst_n_i);

  AST_EXTEST_DRIVE: assert property (extest_i && update_i ##1 extest_i |->
      pad_oe_o[0] == $past(bsr_reg[BSR_FIRST_IO + CELL_OE]) &&
      pad_out_o[0] == $past(bsr_reg[BSR_FIRST_IO + CELL_OUT]))
    else $error("pad drive not taken from boundary cells in external test");
  AST_BSR_SHIFT: assert property (shift_i && !capture_i |=>
      bsr_reg[BSR_UPD] == $past(tdi_i) && bsr_reg[BSR_TDO_T] == $past(bsr_reg[BSR_TDO_O]))
    else $error("boundary register shift path wrong");
  AST_CAPTURE_CELLS: assert property (capture_i |=>
      bsr_reg[BSR_FIRST_IO + CELL_OUT] == $past(core_out_s[0]) &&
      bsr_reg[BSR_FIRST_IO + CELL_OE] == $past(core_oe_s[0]))
    else $error("io_block cells captured in wrong order");
  COV_EXTEST_UPDATE: cover property (extest_i && update_i);
endmodule

// *** hw/scan_tap.sv ***
// Purpose: test access port controller, instruction decode and data registers
// Assumes: tck_i is the link clock; configuration status comes from clk_i
// Notes:   word transfers cross domains by toggle handshakes
`timescale 1ns/10ps
module scan_tap
  import tap_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      resetn_i,
  input  wire logic                      tck_i,
  input  wire logic                      tms_i,
  input  wire logic                      tdi_i,
  output logic                           tdo_o,
  output logic                           tdo_oe_o,
  input  wire logic                      configured_i,
  input  wire logic                      config_busy_i,
  input  wire logic                      scan_option_i,
  output logic      [2:0]                user_pins_o,
  input  wire logic                      user_tdo_i,
  input  wire logic                      user_tdo_oe_i,
  input  wire logic [IO_BLOCK_COUNT-1:0] pad_in_i,
  output logic      [IO_BLOCK_COUNT-1:0] pad_out_o,
  output logic      [IO_BLOCK_COUNT-1:0] pad_oe_o,
  input  wire logic [IO_BLOCK_COUNT-1:0] core_out_i,
  input  wire logic [IO_BLOCK_COUNT-1:0] core_oe_i,
  output logic      [IO_BLOCK_COUNT-1:0] core_in_o,
  output logic                           user_one_select_o,
  output logic                           user_two_select_o,
  input  wire logic                      user_one_scan_out_i,
  input  wire logic                      user_two_scan_out_i,
  output logic                           user_reset_o,
  output logic                           user_update_o,
  output logic                           user_shift_o,
  output logic      [CFG_WORD_LEN-1:0]   config_word_o,
  output logic                           config_word_valid_o,
  input  wire logic [CFG_WORD_LEN-1:0]   readback_word_i,
  output logic                           readback_next_o
);
  tap_state_t              state_reg;
  tap_state_t              state_next;
  logic [1:0]              rst_tck_reg;
  logic                    rst_tck_n;
  logic [2:0]              stat_s;
  logic                    configured_s;
  logic                    busy_s;
  logic                    option_s;
  logic [IR_LEN-1:0]       ir_reg;
  logic [IR_LEN-1:0]       ir_shift_reg;
  logic [IR_LEN-1:0]       active_instr;
  logic                    bypass_reg;
  logic [CFG_WORD_LEN-1:0] cfg_dr_reg;
  logic [CFG_WORD_LEN-1:0] cfg_hold_reg;
  logic                    cfg_tog_reg;
  logic                    rb_req_tog_reg;
  logic                    rb_ack_s;
  logic                    tdo_reg;
  logic                    tdo_en_reg;
  logic                    tdo_next;
  logic                    bsr_tdo;
  logic                    sel_bsr;
  logic                    dedicated;
  // system clock side
  logic                    cfg_tog_s;
  logic                    cfg_tog_seen_reg;
  logic                    rb_req_s;
  logic                    rb_ack_tog_reg;
  logic [CFG_WORD_LEN-1:0] rb_hold_reg;

  // ==========================================================================
  // reset of the test clock domain; power-on only, no test-reset pin
  always_ff @(posedge tck_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_tck_reg <= 2'h0;
    end else begin
      rst_tck_reg <= {rst_tck_reg[0], 1'b1};
    end
  end
  assign rst_tck_n = rst_tck_reg[1];

  sync_2ff #(.WIDTH(3)) u_stat_sync (
    .clk_i   (tck_i),
    .rst_n_i (rst_tck_n),
    .d_i     ({configured_i, config_busy_i, scan_option_i}),
    .q_o     (stat_s)
  );
  assign configured_s = stat_s[2];
  assign busy_s       = stat_s[1];
  assign option_s     = stat_s[0];

  // ==========================================================================
  // pin ownership: test pins are dedicated until a design without scan loads
  assign dedicated   = !configured_i || scan_option_i;
  assign user_pins_o = dedicated ? 3'h0 : {tms_i, tdi_i, tck_i};
  assign tdo_o       = dedicated ? tdo_reg : user_tdo_i;
  assign tdo_oe_o    = dedicated ? tdo_en_reg : user_tdo_oe_i;
  assign core_in_o   = pad_in_i;

  // ==========================================================================
  // controller; tms sampled on the rising test clock edge
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      TLR:      state_next = tms_i ? TLR : RTI;
      RTI:      state_next = tms_i ? SEL_DR : RTI;
      SEL_DR:   state_next = tms_i ? SEL_IR : CAP_DR;
      CAP_DR:   state_next = tms_i ? EXIT1_DR : SHIFT_DR;
      SHIFT_DR: state_next = tms_i ? EXIT1_DR : SHIFT_DR;
      EXIT1_DR: state_next = tms_i ? UPD_DR : PAUSE_DR;
      PAUSE_DR: state_next = tms_i ? EXIT2_DR : PAUSE_DR;
      EXIT2_DR: state_next = tms_i ? UPD_DR : SHIFT_DR;
      UPD_DR:   state_next = tms_i ? SEL_DR : RTI;
      SEL_IR:   state_next = tms_i ? TLR : CAP_IR;
      CAP_IR:   state_next = tms_i ? EXIT1_IR : SHIFT_IR;
      SHIFT_IR: state_next = tms_i ? EXIT1_IR : SHIFT_IR;
      EXIT1_IR: state_next = tms_i ? UPD_IR : PAUSE_IR;
      PAUSE_IR: state_next = tms_i ? EXIT2_IR : PAUSE_IR;
      EXIT2_IR: state_next = tms_i ? UPD_IR : SHIFT_IR;
      UPD_IR:   state_next = tms_i ? SEL_DR : RTI;
      default:  state_next = TLR;
    endcase
  end

  // the four wires alone move the controller; five tms highs reach reset
  always_ff @(posedge tck_i or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      state_reg <= TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // instruction register
  always_ff @(posedge tck_i or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      ir_shift_reg <= IR_CAPTURE;
      ir_reg       <= INS_BYPASS;
    end else begin
      if (state_reg == CAP_IR) begin
        ir_shift_reg <= IR_CAPTURE;
      end else if (state_reg == SHIFT_IR) begin
        ir_shift_reg <= {tdi_i, ir_shift_reg[IR_LEN-1:1]};
      end
      if (state_reg == TLR) begin
        ir_reg <= INS_BYPASS;
      end else if (state_reg == UPD_IR) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // availability; disallowed codes fall back to bypass
  function automatic logic instr_allowed(input logic [IR_LEN-1:0] ins, input logic cfgd,
                                         input logic busy, input logic opt);
    logic pub;
    logic usr;
    pub = (ins == INS_EXTEST) || (ins == INS_SAMPLE) || (ins == INS_BYPASS);
    usr = (ins == INS_USER_ONE) || (ins == INS_USER_TWO);
    if (busy) begin
      // only sample, bypass and the loading path itself during configuration
      instr_allowed = (ins == INS_SAMPLE) || (ins == INS_BYPASS) || (ins == INS_CONFIG);
    end else if (!cfgd) begin
      instr_allowed = pub || (ins == INS_CONFIG);
    end else begin
      instr_allowed = opt && (pub || usr || (ins == INS_READBACK));
    end
  endfunction

  assign active_instr = instr_allowed(ir_reg, configured_s, busy_s, option_s) ? ir_reg : INS_BYPASS;

  // ==========================================================================
  // decodes and user register strobes
  assign sel_bsr           = (active_instr == INS_EXTEST) || (active_instr == INS_SAMPLE);
  assign user_one_select_o = (active_instr == INS_USER_ONE);
  assign user_two_select_o = (active_instr == INS_USER_TWO);
  assign user_reset_o      = (state_reg == TLR);
  assign user_update_o     = (state_reg == UPD_DR);
  assign user_shift_o      = (state_reg == SHIFT_DR);

  boundary_chain u_chain (
    .tck_i       (tck_i),
    .rst_n_i     (rst_tck_n),
    .capture_i   (sel_bsr && state_reg == CAP_DR),
    .shift_i     (sel_bsr && state_reg == SHIFT_DR),
    .update_i    (sel_bsr && state_reg == UPD_DR),
    .extest_i    (active_instr == INS_EXTEST),
    .tdi_i       (tdi_i),
    .tdo_drive_i (tdo_en_reg),
    .tdo_value_i (tdo_reg),
    .pad_in_i    (pad_in_i),
    .core_out_i  (core_out_i),
    .core_oe_i   (core_oe_i),
    .pad_out_o   (pad_out_o),
    .pad_oe_o    (pad_oe_o),
    .scan_out_o  (bsr_tdo)
  );

  // ==========================================================================
  // bypass and configuration data registers
  always_ff @(posedge tck_i or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      bypass_reg <= 1'b0;
      cfg_dr_reg <= '0;
    end else begin
      if (state_reg == CAP_DR) begin
        bypass_reg <= 1'b0;
      end else if (state_reg == SHIFT_DR) begin
        bypass_reg <= tdi_i;
      end
      if (state_reg == CAP_DR && active_instr == INS_READBACK) begin
        // hold word is stable once the answer toggle matches the request
        cfg_dr_reg <= (rb_ack_s == rb_req_tog_reg) ? rb_hold_reg : '0;
      end else if (state_reg == SHIFT_DR) begin
        cfg_dr_reg <= {tdi_i, cfg_dr_reg[CFG_WORD_LEN-1:1]};
      end
    end
  end

  // word handoff toward the system clock, plus next readback request
  always_ff @(posedge tck_i or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      cfg_hold_reg   <= '0;
      cfg_tog_reg    <= 1'b0;
      rb_req_tog_reg <= 1'b0;
    end else if (state_reg == UPD_DR) begin
      if (active_instr == INS_CONFIG) begin
        cfg_hold_reg <= cfg_dr_reg;
        cfg_tog_reg  <= !cfg_tog_reg;
      end
      if (active_instr == INS_READBACK) begin
        rb_req_tog_reg <= !rb_req_tog_reg;
      end
    end
  end

  // ==========================================================================
  // serial output, launched on the falling test clock edge
  always_comb begin
    tdo_next = bypass_reg;
    if (state_reg == SHIFT_IR) begin
      tdo_next = ir_shift_reg[0];
    end else if (sel_bsr) begin
      tdo_next = bsr_tdo;
    end else if (user_one_select_o) begin
      tdo_next = user_one_scan_out_i;
    end else if (user_two_select_o) begin
      tdo_next = user_two_scan_out_i;
    end else if (active_instr == INS_CONFIG || active_instr == INS_READBACK) begin
      tdo_next = cfg_dr_reg[0];
    end
  end

  always_ff @(negedge tck_i or negedge rst_tck_n) begin
    if (!rst_tck_n) begin
      tdo_reg    <= 1'b0;
      tdo_en_reg <= 1'b0;
    end else begin
      tdo_reg    <= tdo_next;
      tdo_en_reg <= (state_reg == SHIFT_DR) || (state_reg == SHIFT_IR);
    end
  end

  // ==========================================================================
  // synchronisers and system clock side of the word handshakes
  sync_2ff #(.WIDTH(2)) u_sys_sync (
    .clk_i   (clk_i),
    .rst_n_i (resetn_i),
    .d_i     ({cfg_tog_reg, rb_req_tog_reg}),
    .q_o     ({cfg_tog_s, rb_req_s})
  );

  sync_2ff #(.WIDTH(1)) u_ack_sync (
    .clk_i   (tck_i),
    .rst_n_i (rst_tck_n),
    .d_i     (rb_ack_tog_reg),
    .q_o     (rb_ack_s)
  );

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_tog_seen_reg    <= 1'b0;
      config_word_o       <= '0;
      config_word_valid_o <= 1'b0;
      rb_ack_tog_reg      <= 1'b0;
      rb_hold_reg         <= '0;
      readback_next_o     <= 1'b0;
    end else begin
      cfg_tog_seen_reg    <= cfg_tog_s;
      config_word_valid_o <= cfg_tog_s != cfg_tog_seen_reg;
      if (cfg_tog_s != cfg_tog_seen_reg) begin
        config_word_o <= cfg_hold_reg;
      end
      readback_next_o <= rb_req_s != rb_ack_tog_reg;
      if (rb_req_s != rb_ack_tog_reg) begin
        rb_hold_reg    <= readback_word_i;
        rb_ack_tog_reg <= rb_req_s;
      end
    end
  end

  // ==========================================================================
  // checks
  AST_TMS_RESET: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      tms_i [*5] |=> state_reg == TLR)
    else $error("five tms highs did not reach test logic reset");
  AST_IR_LOAD: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      state_reg == UPD_IR |=> ir_reg == $past(ir_shift_reg))
    else $error("instruction not loaded at update");
  AST_BYPASS_BIT: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      state_reg == SHIFT_DR && active_instr == INS_BYPASS |=> bypass_reg == $past(tdi_i))
    else $error("bypass flip-flop did not take tdi");
  AST_USER_OUT: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      user_one_select_o && state_reg == SHIFT_DR |-> tdo_next == user_one_scan_out_i)
    else $error("user scan data not steered to tdo");
  AST_USER_UPDATE: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      user_update_o |-> $past(state_reg) inside {EXIT1_DR, EXIT2_DR} ##1 !user_update_o)
    else $error("user update strobe out of sequence");
  AST_LOCKOUT: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      configured_s && !option_s && !busy_s |-> active_instr == INS_BYPASS)
    else $error("instruction usable without scan in design");
  AST_BUSY_LIMIT: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      busy_s |-> active_instr != INS_EXTEST && !user_one_select_o && !user_two_select_o)
    else $error("restricted instruction active during configuration");
  AST_CFG_SEND: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      state_reg == UPD_DR && active_instr == INS_CONFIG |=> cfg_tog_reg != $past(cfg_tog_reg))
    else $error("configuration word not handed over");
  AST_TDO_EDGE: assert property (@(negedge tck_i) disable iff (!rst_tck_n)
      tdo_reg == $past(tdo_next))
    else $error("tdo not launched from the falling test clock");
  AST_USER_SHIFT: assert property (@(posedge tck_i) disable iff (!rst_tck_n)
      user_shift_o |-> $past(state_reg) inside {CAP_DR, SHIFT_DR, EXIT2_DR})
    else $error("user shift strobe outside data shift");
  COV_USER_ONE: cover property (@(posedge tck_i) disable iff (!rst_tck_n)
      user_one_select_o && state_reg == SHIFT_DR);
  COV_CONFIG: cover property (@(posedge clk_i) disable iff (!resetn_i) config_word_valid_o);
  COV_READBACK: cover property (@(posedge clk_i) disable iff (!resetn_i) readback_next_o);
endmodule

// *** tb/scan_controller_model.sv ***
// Purpose: test controller model on the four-wire port
// Assumes: every scan starts and ends in run-test-idle
// Notes:   tck runs only inside calls, so it stands still between frames
`timescale 1ns/10ps
module scan_controller_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  logic seen;
  logic oe_seen;
  logic oe_all;
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end
  // ==========================================================================
  // one cycle: drive after the falling edge, take tdo just before rising
  task tick(input logic m, input logic v);
    tms_o = m;
    tdi_o = v;
    #15 seen = tdo_i;
    oe_seen = tdo_oe_i;
    tck_o = 1'b1;
    #15 tck_o = 1'b0;
  endtask
  task idle(input logic m, input int n);
    repeat (n) tick(m, 1'b0);
  endtask
  // the bench scans during configuration only to see the refusal
  task scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    dout = 16'h0000;
    oe_all = 1'b1;
    tick(1'b1, 1'b0);
    if (ir) tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
    tick(1'b0, 1'b0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i]);
      dout[i] = seen;
      oe_all = oe_all & oe_seen;
    end
    tick(1'b1, 1'b0);
    tick(1'b0, 1'b0);
  endtask
endmodule

// *** tb/fpga_boundary_scan_tap_bench.sv ***
// Purpose: self-checking bench of the test access port
// Assumes: the controller model owns tck, tms and tdi
// Notes:   second user input stays tied low
`timescale 1ns/10ps
module fpga_boundary_scan_tap_bench
  import tap_pkg::*;
;
  logic clk_i = 1'b0, resetn_i, tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, configured_i, config_busy_i, scan_option_i;
  logic user_tdo_i, user_tdo_oe_i, user_one_scan_out_i, user_two_scan_out_i, user_one_select_o, user_two_select_o;
  logic user_reset_o, user_update_o, user_shift_o, config_word_valid_o, readback_next_o;
  logic [2:0]                user_pins_o;
  logic [IO_BLOCK_COUNT-1:0] pad_in_i, pad_out_o, pad_oe_o, core_out_i, core_oe_i, core_in_o, po, pe;
  logic [CFG_WORD_LEN-1:0]   config_word_o, readback_word_i;
  logic [15:0]               d, e;
  int                        fails = 0, compares = 0;
  scan_tap dut_u (.clk_i, .resetn_i, .tck_i, .tms_i, .tdi_i, .tdo_o, .tdo_oe_o, .configured_i, .config_busy_i,
    .scan_option_i, .user_pins_o, .user_tdo_i, .user_tdo_oe_i, .pad_in_i, .pad_out_o, .pad_oe_o, .core_out_i,
    .core_oe_i, .core_in_o, .user_one_select_o, .user_two_select_o, .user_one_scan_out_i, .user_two_scan_out_i,
    .user_reset_o, .user_update_o, .user_shift_o, .config_word_o, .config_word_valid_o, .readback_word_i,
    .readback_next_o);
  scan_controller_model partner_u (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o));
  always #12.5 clk_i = ~clk_i;
  // ==========================================================================
  // helpers
  task check(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task results;
    if (fails == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task ld(input logic [2:0] c);
    partner_u.scan(1'b1, IR_LEN, {13'h0000, c}, d);
  endtask
  // ==========================================================================
  // scenarios
  task t_reset;
    check("user_reset", 16'(user_reset_o), 16'h0001);
    check("user_pins", 16'(user_pins_o), 16'h0000);
    partner_u.idle(1'b0, 1);
  endtask
  task t_bypass;
    ld(INS_BYPASS);
    check("ir_capture", d, 16'(IR_CAPTURE));
    partner_u.scan(1'b0, 8, 16'h00A5, d);
    check("bypass", d, 16'h004A);
    check("tdo_oe", 16'(partner_u.oe_all), 16'h0001);
  endtask
  task t_extest;
    @(posedge clk_i);
    {pad_in_i, core_out_i, core_oe_i} <= 12'hA53;
    ld(INS_EXTEST);
    partner_u.scan(1'b0, BSR_LEN, 16'h2B6C, d);
    e = 16'h0000;
    for (int i = 0; i < IO_BLOCK_COUNT; i++) begin
      e[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OE] = core_oe_i[i];
      e[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OUT] = core_out_i[i];
      e[BSR_FIRST_IO + CELLS_PER_IO * i + CELL_IN] = pad_in_i[i];
      pe[i] = 1'(16'h2B6C >> (BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OE));
      po[i] = 1'(16'h2B6C >> (BSR_FIRST_IO + CELLS_PER_IO * i + CELL_OUT));
    end
    check("capture", d, e);
    check("core_in", 16'(core_in_o), 16'(pad_in_i));
    check("pad_out", 16'(pad_out_o), 16'(po));
    check("pad_oe", 16'(pad_oe_o), 16'(pe));
  endtask
  task t_config;
    ld(INS_CONFIG);
    partner_u.scan(1'b0, CFG_WORD_LEN, 16'h003C, d);
    for (int k = 0; k < 20 && config_word_valid_o !== 1'b1; k++) @(negedge clk_i);
    check("config_valid", 16'(config_word_valid_o), 16'h0001);
    check("config_word", 16'(config_word_o), 16'h003C);
  endtask
  task t_busy;
    @(posedge clk_i) config_busy_i <= 1'b1;
    ld(INS_EXTEST);
    partner_u.scan(1'b0, 8, 16'h00A5, d);
    check("busy_bypass", d, 16'h004A);
    check("busy_pad_oe", 16'(pad_oe_o), 16'(core_oe_i));
    @(posedge clk_i) config_busy_i <= 1'b0;
  endtask
  task t_user;
    ld(INS_USER_ONE);
    check("sel_before_cfg", 16'(user_one_select_o), 16'h0000);
    @(posedge clk_i);
    {configured_i, scan_option_i, user_one_scan_out_i, user_tdo_i} <= 4'hF;
    partner_u.idle(1'b0, 4);
    ld(INS_USER_ONE);
    check("sel_one", 16'(user_one_select_o), 16'h0001);
    partner_u.scan(1'b0, 4, 16'h0000, d);
    check("user_data", d, 16'h000F);
    ld(INS_USER_TWO);
    check("sel_two", 16'(user_two_select_o), 16'h0001);
    @(posedge clk_i) scan_option_i <= 1'b0;
    #1 check("tdo_user", 16'(tdo_o), 16'h0001);
  endtask
  task t_readback;
    partner_u.idle(1'b0, 3);
    check("lockout", 16'(user_two_select_o), 16'h0000);
    @(posedge clk_i);
    {scan_option_i, readback_word_i} <= 9'h1C3;
    ld(INS_READBACK);
    partner_u.scan(1'b0, CFG_WORD_LEN, 16'h0000, d);
    check("readback_first", d, 16'h0000);
    for (int k = 0; k < 20 && readback_next_o !== 1'b1; k++) @(negedge clk_i);
    check("readback_next", 16'(readback_next_o), 16'h0001);
    partner_u.idle(1'b0, 4);
    partner_u.scan(1'b0, CFG_WORD_LEN, 16'h0000, d);
    check("readback_word", d, 16'h00C3);
  endtask
  initial begin
    {resetn_i, configured_i, config_busy_i, scan_option_i, user_tdo_i, user_tdo_oe_i} = 6'h00;
    {user_one_scan_out_i, user_two_scan_out_i, pad_in_i, core_out_i, core_oe_i} = 14'h0000;
    readback_word_i = 8'h00;
    fork
      begin repeat (20) @(posedge clk_i); resetn_i <= 1'b1; end
      partner_u.idle(1'b1, 20);
    join
    t_reset;
    t_bypass;
    t_extest;
    t_config;
    t_busy;
    t_user;
    t_readback;
    results;
  end
  initial begin
    #50000;
    fails++;
    results;
  end
endmodule
